// ---- pkg/cbs_pkg.sv ----
// constants and types shared by the bus and state sequencer
package cbs_pkg;
  // the core clock stands in for the crystal
  localparam int CLK_PERIOD_NS = 4;
  localparam int STATE_CRYSTAL_PERIODS = 2;
  localparam int STATE_NS = STATE_CRYSTAL_PERIODS * CLK_PERIOD_NS;
  localparam int STATE_CYCLES = STATE_NS / CLK_PERIOD_NS;
  localparam int WAIT_STEP_NS = CLK_PERIOD_NS;
  localparam int WAIT_STEP_CYCLES = WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam int WORD_W = 12;
  localparam int REQ_LINES = 4;
  localparam int SENSE_W = 4;
  localparam int SENSE_SKIP = 0;
  localparam int SENSE_C0 = 1;
  localparam int SENSE_C1 = 2;
  localparam int SENSE_C2 = 3;
  localparam logic [11:0] WORD_RESET = 12'h000;
  localparam logic [2:0] STATE_CODE_IDLE = 3'h0;

  typedef enum logic [2:0] {
    KIND_FETCH,
    KIND_MEM_READ,
    KIND_MEM_WRITE,
    KIND_IO,
    KIND_PANEL_READ,
    KIND_PANEL_WRITE,
    KIND_SWITCH_READ
  } cbs_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_T3,
    ST_T4,
    ST_T5
  } cbs_state_t;
endpackage : cbs_pkg

// ---- hw/cbs_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cbs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule : cbs_sync

// ---- hw/cbs_state_tick.sv ----
// divider that marks the last crystal period of a major state
`timescale 1ns/10ps
module cbs_state_tick #(
  parameter int PERIODS = cbs_pkg::STATE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic restart_i,
  output logic tick_o
);
  localparam int CW = (PERIODS > 1) ? $clog2(PERIODS) : 1;
  localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // refused at elaboration: a state needs at least one crystal period
  if (PERIODS < 1) begin : g_bad_periods
    $error("cbs_state_tick: PERIODS must be at least 1");
  end

  always_comb begin
    if (restart_i || cnt_q == LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign tick_o = (cnt_q == LAST) && !restart_i;
endmodule : cbs_state_tick

// ---- hw/cbs_sequencer.sv ----
// external bus and major state sequencer of a 12-bit processor
// Overview of operation
// - each major state lasts two crystal (clock) periods
// - memory cycles drive the address in T1 with the latch strobe
// - I/O cycles drive the instruction word in T1 for the outside latch
// - request lines are priority sampled in T1 only before a fetch
// - the current major state is shown on output lines
// - input data is read in T2; wait held active keeps T2
// - wait stretches T2 in whole crystal periods
// - memory select for memory cycles, peripheral select for I/O cycles
// - I/O cycles sample skip and three control lines and steer the cycle
// - panel memory and switch bank selects go low for their transfers
// - T3, T4 and T5 make no external transfer
// - write data stays on the bus in T2 while wait is held
`timescale 1ns/10ps
module cbs_sequencer #(
  parameter int WIDTH = cbs_pkg::WORD_W,
  parameter int LINES = cbs_pkg::REQ_LINES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // request from the core
  input wire logic req_valid_i,
  input wire cbs_pkg::cbs_kind_t req_kind_i,
  input wire logic [WIDTH-1:0] req_addr_i,
  input wire logic [WIDTH-1:0] req_wdata_i,
  input wire logic req_next_fetch_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [WIDTH-1:0] rsp_rdata_o,
  output logic [cbs_pkg::SENSE_W-1:0] io_sense_o,
  output logic [LINES-1:0] prio_grant_o,
  output logic cycle_done_o,
  output logic [2:0] major_state_o,
  // pins
  input wire logic [WIDTH-1:0] muxed_bus_i,
  output logic [WIDTH-1:0] muxed_bus_o,
  output logic muxed_bus_oe_o,
  output logic address_latch_strobe_o,
  output logic read_strobe_o,
  output logic write_strobe_o,
  output logic memory_select_o,
  output logic peripheral_select_o,
  output logic panel_memory_select_n_o,
  output logic switch_bank_select_n_o,
  input wire logic wait_i,
  input wire logic skip_request_i,
  input wire logic io_control_0_i,
  input wire logic io_control_1_i,
  input wire logic io_control_2_i,
  input wire logic [LINES-1:0] ext_request_i
);
  // refused at elaboration: the bus word is fixed by the package constants
  if (WIDTH != cbs_pkg::WORD_W || LINES < 1) begin : g_bad_params
    $error("cbs_sequencer: unsupported WIDTH or LINES");
  end

  function automatic logic [LINES-1:0] pick_first(input logic [LINES-1:0] lines);
    logic [LINES-1:0] grant;
    grant = '0;
    for (int i = LINES - 1; i >= 0; i--) begin
      if (lines[i]) begin
        grant = '0;
        grant[i] = 1'b1;
      end
    end
    return grant;
  endfunction : pick_first

  function automatic logic is_mem(input cbs_pkg::cbs_kind_t k);
    return k == cbs_pkg::KIND_FETCH || k == cbs_pkg::KIND_MEM_READ ||
           k == cbs_pkg::KIND_MEM_WRITE;
  endfunction : is_mem

  // pin inputs pass two flops; bus data latency is hidden inside T2
  logic [WIDTH-1:0] bus_s;
  logic wait_s;
  logic [cbs_pkg::SENSE_W-1:0] sense_s;
  logic [LINES-1:0] ext_s;
  logic tick;
  logic restart;

  cbs_sync #(.WIDTH(WIDTH + 1 + cbs_pkg::SENSE_W + LINES)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({muxed_bus_i, wait_i, io_control_2_i, io_control_1_i, io_control_0_i,
          skip_request_i, ext_request_i}),
    .q_o({bus_s, wait_s, sense_s, ext_s})
  );

  cbs_state_tick #(.PERIODS(cbs_pkg::STATE_CYCLES)) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart),
    .tick_o(tick)
  );

  cbs_pkg::cbs_state_t st_q, st_d;
  cbs_pkg::cbs_kind_t kind_q, kind_d;
  logic [WIDTH-1:0] addr_q, addr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic rd_q, rd_d, nf_q, nf_d, rsp_q, rsp_d, done_q, done_d;
  logic [cbs_pkg::SENSE_W-1:0] sense_q, sense_d;
  logic [LINES-1:0] grant_q, grant_d;
  logic take;

  assign take = (st_q == cbs_pkg::ST_IDLE) && req_valid_i;
  // waiting keeps the divider at zero so release lands on a crystal edge
  assign restart = take || (st_q == cbs_pkg::ST_T2 && wait_s);

  always_comb begin
    st_d = st_q;
    kind_d = kind_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    rd_d = rd_q;
    nf_d = nf_q;
    sense_d = sense_q;
    grant_d = grant_q;
    rsp_d = 1'b0;
    done_d = 1'b0;
    unique case (st_q)
      cbs_pkg::ST_IDLE: begin
        if (take) begin
          st_d = cbs_pkg::ST_T1;
          kind_d = req_kind_i;
          addr_d = req_addr_i;
          wdata_d = req_wdata_i;
          nf_d = req_next_fetch_i;
          rd_d = req_kind_i == cbs_pkg::KIND_FETCH || req_kind_i == cbs_pkg::KIND_MEM_READ ||
                 req_kind_i == cbs_pkg::KIND_PANEL_READ ||
                 req_kind_i == cbs_pkg::KIND_SWITCH_READ;
        end
      end
      cbs_pkg::ST_T1: begin
        if (tick) begin
          st_d = cbs_pkg::ST_T2;
          if (nf_q) begin
            grant_d = pick_first(ext_s);
          end
          if (kind_q == cbs_pkg::KIND_IO) begin
            sense_d = sense_s;
            // control line 0 turns the I/O transfer into an input
            rd_d = sense_s[cbs_pkg::SENSE_C0];
          end
        end
      end
      cbs_pkg::ST_T2: begin
        if (tick) begin
          st_d = cbs_pkg::ST_T3;
          rsp_d = 1'b1;
          if (rd_q) begin
            rdata_d = bus_s;
          end
        end
      end
      cbs_pkg::ST_T3: begin
        if (tick) begin
          st_d = cbs_pkg::ST_T4;
        end
      end
      cbs_pkg::ST_T4: begin
        if (tick) begin
          st_d = cbs_pkg::ST_T5;
        end
      end
      cbs_pkg::ST_T5: begin
        if (tick) begin
          st_d = cbs_pkg::ST_IDLE;
          done_d = 1'b1;
        end
      end
    endcase
  end

  // pin outputs are computed from the next state so they register with it
  logic [WIDTH-1:0] bus_d;
  logic oe_d, als_d, rds_d, wrs_d, msel_d, psel_d, panel_memory_select_n_d, switch_bank_select_n_d;
  logic [WIDTH-1:0] bus_q;
  logic oe_q, als_q, rds_q, wrs_q, msel_q, psel_q, panel_memory_select_n_q, switch_bank_select_n_q;
  logic t12;

  always_comb begin
    t12 = st_d == cbs_pkg::ST_T1 || st_d == cbs_pkg::ST_T2;
    bus_d = cbs_pkg::WORD_RESET;
    oe_d = 1'b0;
    als_d = 1'b0;
    rds_d = 1'b0;
    wrs_d = 1'b0;
    if (st_d == cbs_pkg::ST_T1) begin
      bus_d = addr_d;
      oe_d = 1'b1;
      als_d = 1'b1;
    end else if (st_d == cbs_pkg::ST_T2) begin
      rds_d = rd_d;
      wrs_d = !rd_d;
      oe_d = !rd_d;
      bus_d = rd_d ? cbs_pkg::WORD_RESET : wdata_d;
    end
    msel_d = t12 && is_mem(kind_d);
    psel_d = t12 && kind_d == cbs_pkg::KIND_IO;
    panel_memory_select_n_d = !(t12 && (kind_d == cbs_pkg::KIND_PANEL_READ ||
                          kind_d == cbs_pkg::KIND_PANEL_WRITE));
    switch_bank_select_n_d = !(t12 && kind_d == cbs_pkg::KIND_SWITCH_READ);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= cbs_pkg::ST_IDLE;
      kind_q <= cbs_pkg::KIND_FETCH;
      addr_q <= cbs_pkg::WORD_RESET;
      wdata_q <= cbs_pkg::WORD_RESET;
      rdata_q <= cbs_pkg::WORD_RESET;
      rd_q <= 1'b0;
      nf_q <= 1'b0;
      sense_q <= '0;
      grant_q <= '0;
      rsp_q <= 1'b0;
      done_q <= 1'b0;
      bus_q <= cbs_pkg::WORD_RESET;
      oe_q <= 1'b0;
      als_q <= 1'b0;
      rds_q <= 1'b0;
      wrs_q <= 1'b0;
      msel_q <= 1'b0;
      psel_q <= 1'b0;
      panel_memory_select_n_q <= 1'b1;
      switch_bank_select_n_q <= 1'b1;
    end else begin
      st_q <= st_d;
      kind_q <= kind_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      rd_q <= rd_d;
      nf_q <= nf_d;
      sense_q <= sense_d;
      grant_q <= grant_d;
      rsp_q <= rsp_d;
      done_q <= done_d;
      bus_q <= bus_d;
      oe_q <= oe_d;
      als_q <= als_d;
      rds_q <= rds_d;
      wrs_q <= wrs_d;
      msel_q <= msel_d;
      psel_q <= psel_d;
      panel_memory_select_n_q <= panel_memory_select_n_d;
      switch_bank_select_n_q <= switch_bank_select_n_d;
    end
  end

  assign req_ready_o = st_q == cbs_pkg::ST_IDLE;
  assign rsp_valid_o = rsp_q;
  assign rsp_rdata_o = rdata_q;
  assign io_sense_o = sense_q;
  assign prio_grant_o = grant_q;
  assign cycle_done_o = done_q;
  assign major_state_o = st_q;
  assign muxed_bus_o = bus_q;
  assign muxed_bus_oe_o = oe_q;
  assign address_latch_strobe_o = als_q;
  assign read_strobe_o = rds_q;
  assign write_strobe_o = wrs_q;
  assign memory_select_o = msel_q;
  assign peripheral_select_o = psel_q;
  assign panel_memory_select_n_o = panel_memory_select_n_q;
  assign switch_bank_select_n_o = switch_bank_select_n_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  state_period_a: assert property (
    (st_q == cbs_pkg::ST_T3 && $past(st_q) == cbs_pkg::ST_T2) |->
      (st_q == cbs_pkg::ST_T3) [*2] ##1 (st_q == cbs_pkg::ST_T4))
    else $error("T3 did not last two clocks");
  addr_phase_a: assert property (
    (st_q == cbs_pkg::ST_T1 && is_mem(kind_q)) |->
      muxed_bus_oe_o && address_latch_strobe_o && muxed_bus_o == addr_q)
    else $error("memory address missing in T1");
  io_word_a: assert property (
    (take && req_kind_i == cbs_pkg::KIND_IO) |=>
      muxed_bus_o == $past(req_addr_i) && muxed_bus_oe_o && peripheral_select_o)
    else $error("instruction word not driven in T1");
  prio_sample_a: assert property (
    (st_q == cbs_pkg::ST_T1 && tick) |=>
      prio_grant_o == ($past(nf_q) ? pick_first($past(ext_s)) : $past(grant_q)))
    else $error("priority sampled at wrong time");
  state_show_a: assert property (
    major_state_o <= 3'h5 && (major_state_o == 3'h1) == address_latch_strobe_o &&
      (major_state_o == 3'h2) == (read_strobe_o || write_strobe_o))
    else $error("state lines do not follow state");
  wait_hold_a: assert property (
    (st_q == cbs_pkg::ST_T2 && wait_s) |=> st_q == cbs_pkg::ST_T2)
    else $error("left T2 while waiting");
  wait_step_a: assert property (
    (st_q == cbs_pkg::ST_T2 && $past(wait_s) && !wait_s) |->
      ##1 (st_q == cbs_pkg::ST_T2 || wait_s) ##1 (st_q != cbs_pkg::ST_T2 || wait_s))
    else $error("wait release not in whole clock steps");
  select_kind_a: assert property (
    (st_q == cbs_pkg::ST_T1) |->
      memory_select_o == is_mem(kind_q) &&
      peripheral_select_o == (kind_q == cbs_pkg::KIND_IO))
    else $error("select does not match cycle kind");
  sense_sample_a: assert property (
    (st_q == cbs_pkg::ST_T1 && tick && kind_q == cbs_pkg::KIND_IO) |=>
      io_sense_o == $past(sense_s) && read_strobe_o == $past(sense_s[cbs_pkg::SENSE_C0]))
    else $error("sense lines not sampled");
  panel_low_a: assert property (
    (st_q == cbs_pkg::ST_T2 && kind_q == cbs_pkg::KIND_SWITCH_READ) |->
      !switch_bank_select_n_o && panel_memory_select_n_o && !memory_select_o)
    else $error("switch bank select not low");
  internal_quiet_a: assert property (
    (st_q == cbs_pkg::ST_T3 || st_q == cbs_pkg::ST_T4 || st_q == cbs_pkg::ST_T5) |->
      !muxed_bus_oe_o && !read_strobe_o && !write_strobe_o && !memory_select_o &&
      !peripheral_select_o && panel_memory_select_n_o && switch_bank_select_n_o)
    else $error("external activity in internal state");
  write_hold_a: assert property (
    (st_q == cbs_pkg::ST_T2 && !rd_q && wait_s) |=>
      muxed_bus_oe_o && muxed_bus_o == $past(wdata_q) && write_strobe_o)
    else $error("write data dropped during wait");
  bus_release_a: assert property (
    (st_q == cbs_pkg::ST_T2 && rd_q) |-> !muxed_bus_oe_o && read_strobe_o)
    else $error("bus driven while reading");
endmodule : cbs_sequencer

// ---- dv/cbs_far_side.sv ----
// far side model: memory and peripheral answering the multiplexed bus
`timescale 1ns/10ps
module cbs_far_side (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [11:0] muxed_bus_o,
  input wire logic muxed_bus_oe_o,
  input wire logic address_latch_strobe_o,
  input wire logic read_strobe_o,
  input wire logic write_strobe_o,
  input wire logic [3:0] wait_len_i,
  output logic [11:0] muxed_bus_i,
  output logic wait_i
);
  logic [11:0] mem [16];
  logic [3:0] addr_q;
  logic [3:0] wcnt_q;
  logic act_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 12'hA50 + 12'(i);
      end
      act_q <= 1'b0;
      addr_q <= 4'h0;
      wcnt_q <= 4'h0;
      wait_i <= 1'b0;
      muxed_bus_i <= 12'h5A5;
    end else if (address_latch_strobe_o && !act_q) begin
      act_q <= 1'b1;
      addr_q <= muxed_bus_o[3:0];
      // data goes out at once: the design samples two cycles late
      muxed_bus_i <= mem[muxed_bus_o[3:0]];
      wait_i <= (wait_len_i != 4'h0);
      wcnt_q <= wait_len_i;
    end else if (act_q) begin
      if (wcnt_q > 4'h1) begin
        wcnt_q <= wcnt_q - 4'h1;
      end else begin
        wait_i <= 1'b0;
      end
      if (write_strobe_o && muxed_bus_oe_o) begin
        mem[addr_q] <= muxed_bus_o;
      end
      if (!address_latch_strobe_o && !read_strobe_o && !write_strobe_o) begin
        act_q <= 1'b0;
        muxed_bus_i <= ~muxed_bus_i;
      end
    end else begin
      // released bus shows a changing pattern, never a stale word
      muxed_bus_i <= ~muxed_bus_i;
    end
  end
endmodule : cbs_far_side

// ---- dv/testbench.sv ----
// self-checking testbench for the bus and state sequencer
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_valid_i = 1'b0;
  cbs_pkg::cbs_kind_t req_kind_i = cbs_pkg::KIND_FETCH;
  logic [11:0] req_addr_i = 12'h000;
  logic [11:0] req_wdata_i = 12'h000;
  logic req_next_fetch_i = 1'b0;
  logic skip_request_i = 1'b0;
  logic io_control_0_i = 1'b0;
  logic io_control_1_i = 1'b0;
  logic io_control_2_i = 1'b0;
  logic [3:0] ext_request_i = 4'h0;
  logic [3:0] wait_len_i = 4'h0;
  logic req_ready_o, rsp_valid_o, cycle_done_o, wait_i, muxed_bus_oe_o;
  logic [11:0] rsp_rdata_o, muxed_bus_i, muxed_bus_o, t1_bus, rdata;
  logic [3:0] io_sense_o, prio_grant_o;
  logic [2:0] major_state_o;
  logic address_latch_strobe_o, read_strobe_o, write_strobe_o;
  logic memory_select_o, peripheral_select_o, panel_memory_select_n_o, switch_bank_select_n_o;
  logic rs_seen, msel, psel, pn_low, sn_low, oe_rd, late, held;
  logic [5:0] seen;
  int ls_cnt, t2cnt, rsp_at, done_at, n;
  int num_errors = 0;
  int compares = 0;

  cbs_sequencer u_cbs_sequencer (.clk_i, .rst_i, .req_valid_i, .req_kind_i, .req_addr_i,
    .req_wdata_i, .req_next_fetch_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .io_sense_o,
    .prio_grant_o, .cycle_done_o, .major_state_o, .muxed_bus_i, .muxed_bus_o, .muxed_bus_oe_o,
    .address_latch_strobe_o, .read_strobe_o, .write_strobe_o, .memory_select_o,
    .peripheral_select_o, .panel_memory_select_n_o, .switch_bank_select_n_o, .wait_i,
    .skip_request_i, .io_control_0_i, .io_control_1_i, .io_control_2_i, .ext_request_i);
  cbs_far_side u_cbs_far_side (.clk_i, .rst_i, .muxed_bus_o, .muxed_bus_oe_o,
    .address_latch_strobe_o, .read_strobe_o, .write_strobe_o, .wait_len_i, .muxed_bus_i,
    .wait_i);

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %0t value %h, wanted %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // one whole transfer, watched at falling edges until the done pulse
  task automatic op(input cbs_pkg::cbs_kind_t k, input logic [11:0] a, input logic [11:0] d,
                    input logic nf);
    int g;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_kind_i <= k;
    req_addr_i <= a;
    req_wdata_i <= d;
    req_next_fetch_i <= nf;
    g = 0;
    @(negedge clk_i);
    while (req_ready_o !== 1'b1 && g < 50) begin
      @(negedge clk_i);
      g++;
    end
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    {rs_seen, msel, psel, pn_low, sn_low, oe_rd, late, held} = 8'h01;
    {ls_cnt, t2cnt, rsp_at, done_at, n, seen} = '0;
    while (n < 200 && done_at == 0) begin
      @(negedge clk_i);
      n++;
      seen[major_state_o] = 1'b1;
      case (major_state_o)
        3'h1: begin
          t1_bus = muxed_bus_o;
          ls_cnt += int'(address_latch_strobe_o);
          msel |= memory_select_o;
          psel |= peripheral_select_o;
          pn_low |= ~panel_memory_select_n_o;
          sn_low |= ~switch_bank_select_n_o;
        end
        3'h2: begin
          t2cnt++;
          rs_seen |= read_strobe_o;
          oe_rd |= read_strobe_o & muxed_bus_oe_o;
          if (write_strobe_o && (muxed_bus_o !== d || !muxed_bus_oe_o)) held = 1'b0;
        end
        3'h3, 3'h4, 3'h5: begin
          late |= address_latch_strobe_o | read_strobe_o | write_strobe_o | muxed_bus_oe_o;
          late |= memory_select_o | peripheral_select_o;
          late |= ~panel_memory_select_n_o | ~switch_bank_select_n_o;
        end
        default: ;
      endcase
      if (rsp_valid_o) rdata = rsp_rdata_o;
      if (rsp_valid_o) rsp_at = n;
      if (cycle_done_o) done_at = n;
    end
    chk(t1_bus, a);
    chk(12'(ls_cnt), 12'h002);
    chk(12'(done_at), 12'(rsp_at + 6));
    chk(12'(rsp_at), 12'(t2cnt + 3));
    chk(late, 1'b0);
    chk(seen[5:1], 5'h1F);
  endtask : op

  task automatic t_reset();
    chk({major_state_o, muxed_bus_oe_o}, 4'h0);
    chk(req_ready_o, 1'b1);
    chk({panel_memory_select_n_o, switch_bank_select_n_o}, 2'h3);
  endtask : t_reset

  task automatic t_mem();
    op(cbs_pkg::KIND_MEM_WRITE, 12'h005, 12'h3C7, 1'b0);
    chk(12'(rsp_at), 12'h005);
    chk({msel, psel, held}, 3'h5);
    chk(rs_seen, 1'b0);
    op(cbs_pkg::KIND_MEM_READ, 12'h005, 12'h000, 1'b0);
    chk(rdata, 12'h3C7);
    chk(oe_rd, 1'b0);
    chk(rs_seen, 1'b1);
    op(cbs_pkg::KIND_FETCH, 12'h00A, 12'h000, 1'b0);
    chk(rdata, 12'hA5A);
  endtask : t_mem

  task automatic t_wait();
    wait_len_i <= 4'h6;
    op(cbs_pkg::KIND_MEM_WRITE, 12'h006, 12'h123, 1'b0);
    chk(t2cnt > 2, 1'b1);
    chk(held, 1'b1);
    op(cbs_pkg::KIND_MEM_READ, 12'h006, 12'h000, 1'b0);
    chk(t2cnt > 2, 1'b1);
    chk(12'(t2cnt), 12'h009);
    chk(rdata, 12'h123);
    wait_len_i <= 4'h0;
  endtask : t_wait

  task automatic t_io();
    @(posedge clk_i);
    {io_control_2_i, io_control_1_i, io_control_0_i, skip_request_i} <= 4'hB;
    op(cbs_pkg::KIND_IO, 12'h603, 12'h000, 1'b0);
    chk({msel, psel}, 2'h1);
    chk(io_sense_o, 4'hB);
    chk({rdata, oe_rd}, {12'hA53, 1'b0});
    @(posedge clk_i);
    {io_control_2_i, io_control_1_i, io_control_0_i, skip_request_i} <= 4'h4;
    op(cbs_pkg::KIND_IO, 12'h604, 12'h0F0, 1'b0);
    chk(io_sense_o, 4'h4);
    chk(held, 1'b1);
    op(cbs_pkg::KIND_MEM_READ, 12'h004, 12'h000, 1'b0);
    chk(rdata, 12'h0F0);
  endtask : t_io

  task automatic t_panel();
    cbs_pkg::cbs_kind_t ks [3];
    ks = '{cbs_pkg::KIND_PANEL_READ, cbs_pkg::KIND_PANEL_WRITE, cbs_pkg::KIND_SWITCH_READ};
    for (int i = 0; i < 3; i++) begin
      op(ks[i], 12'h007, 12'h2B4, 1'b0);
      chk({pn_low, sn_low, msel, psel}, (i == 2) ? 4'h4 : 4'h8);
    end
  endtask : t_panel

  task automatic t_prio();
    @(posedge clk_i);
    ext_request_i <= 4'h6;
    op(cbs_pkg::KIND_MEM_READ, 12'h001, 12'h000, 1'b1);
    chk(prio_grant_o, 4'h2);
    @(posedge clk_i);
    ext_request_i <= 4'h1;
    op(cbs_pkg::KIND_MEM_READ, 12'h001, 12'h000, 1'b0);
    chk(prio_grant_o, 4'h2);
    op(cbs_pkg::KIND_MEM_READ, 12'h001, 12'h000, 1'b1);
    chk(prio_grant_o, 4'h1);
  endtask : t_prio

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_mem();
    t_wait();
    t_io();
    t_panel();
    t_prio();
    results();
  end

  // about 14 transfers of some 13 cycles each; far more means a hang
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    results();
  end
endmodule : testbench
